// ===== design/rx_irq_defs.svh
`ifndef RX_IRQ_DEFS_SVH
`define RX_IRQ_DEFS_SVH

// ============================================================
// register offsets
`define RXI_ADDR_PORT_SEL 8'h4c
`define RXI_ADDR_CAM_STS 8'h7a
`define RXI_ADDR_STS_FIRST 8'h60
`define RXI_ADDR_STS_SECOND 8'h61
`define RXI_ADDR_IE_HIGH 8'hd8
`define RXI_ADDR_IE_LOW 8'hd9
`define RXI_ADDR_IRQ_HIGH 8'hda
`define RXI_ADDR_IRQ_LOW 8'hdb
`define RXI_ADDR_GPIO_STS 8'hdc
`define RXI_ADDR_GPIO_IE 8'hdd
`define RXI_ADDR_SEN_RISE 8'hde
`define RXI_ADDR_SEN_FALL 8'hdf

// ============================================================
// high status field positions
`define RXI_HI_GPIO 4
`define RXI_HI_SENSOR 3
`define RXI_HI_ENC 2
`define RXI_HI_SEQ 1
`define RXI_HI_CRC 0

// ============================================================
// low status field positions
`define RXI_LO_LEN 6
`define RXI_LO_CNT 5
`define RXI_LO_BUF 4
`define RXI_LO_CAM 3
`define RXI_LO_PAR 2
`define RXI_LO_VALID 1
`define RXI_LO_LOCK 0

// ============================================================
// gpio status layout, writable masks and reset values
`define RXI_GPIO_LATCH_LSB 4
`define RXI_IE_HIGH_MASK 8'h07
`define RXI_RESET_BYTE 8'h00

`endif

// ===== design/rx_irq_pkg.sv
`default_nettype none

package rx_irq_pkg;

    // one-cycle event pulses of one receive port
    typedef struct packed {
        logic linkEncErr;
        logic ctrlSeqErr;
        logic ctrlCrcErr;
        logic lineLenChg;
        logic lineCntChg;
        logic bufOverflow;
        logic cameraRxErr;
        logic linkParErr;
        logic portValidChg;
        logic lockChg;
        logic sensorChg;
    } port_evt_t;

    typedef logic [7:0] reg_byte_t;
    typedef logic [3:0] gpio_t;

endpackage

`default_nettype wire

// ===== design/rx_irq_bank_if.sv
`default_nettype none

interface rx_irq_bank_if;
    import rx_irq_pkg::*;

    port_evt_t evt;
    gpio_t gpioLive;
    reg_byte_t ieHigh;
    reg_byte_t ieLow;
    reg_byte_t ieGpio;
    logic rdStsFirst;
    logic rdStsSecond;
    logic rdCamSts;
    logic rdSenRise;
    logic rdSenFall;
    logic rdGpioSts;
    reg_byte_t statusHigh;
    reg_byte_t statusLow;
    reg_byte_t gpioStatus;

    modport ctrl (
        output evt, gpioLive, ieHigh, ieLow, ieGpio,
        output rdStsFirst, rdStsSecond, rdCamSts,
        output rdSenRise, rdSenFall, rdGpioSts,
        input statusHigh, statusLow, gpioStatus
    );

    modport bank (
        input evt, gpioLive, ieHigh, ieLow, ieGpio,
        input rdStsFirst, rdStsSecond, rdCamSts,
        input rdSenRise, rdSenFall, rdGpioSts,
        output statusHigh, statusLow, gpioStatus
    );

endinterface

`default_nettype wire

// ===== design/rx_port_irq_bank.sv
`include "rx_irq_defs.svh"
`default_nettype none

module rx_port_irq_bank (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // control side
    rx_irq_bank_if.bank bus
);
    import rx_irq_pkg::*;

    typedef struct packed {
        reg_byte_t high;
        reg_byte_t low;
        gpio_t gpioLatch;
        gpio_t gpioPrev;
        logic riseSeen;
        logic fallSeen;
    } bank_state_t;

    bank_state_t s_r;
    bank_state_t s_nxt;
    gpio_t gpioMet;
    reg_byte_t setHigh;
    reg_byte_t clrHigh;
    reg_byte_t setLow;
    reg_byte_t clrLow;
    logic riseRead;
    logic fallRead;
    logic bothRead;

    // a set in the clearing cycle wins over the clear
    function automatic reg_byte_t sticky(reg_byte_t cur, reg_byte_t set,
                                         reg_byte_t clr);
        return (cur & ~clr) | set;
    endfunction

    // ============================================================
    // flag update
    always_comb begin
        s_nxt = s_r;
        for (int i = 0; i < 4; i++) begin
            gpioMet[i] = (bus.gpioLive[i] & ~s_r.gpioPrev[i]
                          & bus.ieGpio[2 * i])
                       | (~bus.gpioLive[i] & s_r.gpioPrev[i]
                          & bus.ieGpio[2 * i + 1]);
        end
        s_nxt.gpioPrev = bus.gpioLive;
        s_nxt.gpioLatch = (s_r.gpioLatch & ~{4{bus.rdGpioSts}}) | gpioMet;

        riseRead = s_r.riseSeen | bus.rdSenRise;
        fallRead = s_r.fallSeen | bus.rdSenFall;
        bothRead = riseRead & fallRead;
        s_nxt.riseSeen = s_r.high[`RXI_HI_SENSOR] & riseRead & ~bothRead;
        s_nxt.fallSeen = s_r.high[`RXI_HI_SENSOR] & fallRead & ~bothRead;

        setHigh = `RXI_RESET_BYTE;
        clrHigh = `RXI_RESET_BYTE;
        setHigh[`RXI_HI_GPIO] = |gpioMet;
        clrHigh[`RXI_HI_GPIO] = bus.rdGpioSts;
        setHigh[`RXI_HI_SENSOR] = bus.evt.sensorChg;
        clrHigh[`RXI_HI_SENSOR] = bothRead;
        setHigh[`RXI_HI_ENC] = bus.evt.linkEncErr & bus.ieHigh[`RXI_HI_ENC];
        setHigh[`RXI_HI_SEQ] = bus.evt.ctrlSeqErr & bus.ieHigh[`RXI_HI_SEQ];
        setHigh[`RXI_HI_CRC] = bus.evt.ctrlCrcErr & bus.ieHigh[`RXI_HI_CRC];
        clrHigh[`RXI_HI_ENC] = bus.rdStsSecond;
        clrHigh[`RXI_HI_SEQ] = bus.rdStsFirst;
        clrHigh[`RXI_HI_CRC] = bus.rdStsFirst;

        setLow = `RXI_RESET_BYTE;
        setLow[`RXI_LO_LEN] = bus.evt.lineLenChg;
        setLow[`RXI_LO_CNT] = bus.evt.lineCntChg;
        setLow[`RXI_LO_BUF] = bus.evt.bufOverflow;
        setLow[`RXI_LO_CAM] = bus.evt.cameraRxErr;
        setLow[`RXI_LO_PAR] = bus.evt.linkParErr;
        setLow[`RXI_LO_VALID] = bus.evt.portValidChg;
        setLow[`RXI_LO_LOCK] = bus.evt.lockChg;
        setLow = setLow & bus.ieLow & 8'h7f;
        clrLow = `RXI_RESET_BYTE;
        clrLow[`RXI_LO_LEN] = bus.rdStsSecond;
        clrLow[`RXI_LO_CNT] = bus.rdStsSecond;
        clrLow[`RXI_LO_BUF] = bus.rdStsSecond;
        clrLow[`RXI_LO_CAM] = bus.rdCamSts;
        clrLow[`RXI_LO_PAR] = bus.rdStsFirst;
        clrLow[`RXI_LO_VALID] = bus.rdStsFirst;
        clrLow[`RXI_LO_LOCK] = bus.rdStsFirst;

        s_nxt.high = sticky(s_r.high, setHigh, clrHigh);
        s_nxt.low = sticky(s_r.low, setLow, clrLow);
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bus.gpioStatus = {s_r.gpioLatch, bus.gpioLive};
    assign bus.statusHigh = s_r.high;
    assign bus.statusLow = s_r.low;

    // ============================================================
    // checks
    crc_flag_set_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        bus.evt.ctrlCrcErr && bus.ieHigh[0] |=> bus.statusHigh[0])
        else $error("crc flag not set");
    enc_flag_clear_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        bus.rdStsSecond && !bus.evt.linkEncErr |=> !bus.statusHigh[2])
        else $error("encoding flag not cleared");
    sensor_half_read_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        bus.statusHigh[3] && !s_r.fallSeen && bus.rdSenRise
        && !bus.rdSenFall ##1 !bus.rdSenFall [*2] |-> bus.statusHigh[3])
        else $error("sensor flag cleared by one read");
    sensor_both_read_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        s_r.riseSeen && bus.rdSenFall && !bus.evt.sensorChg
        |=> !bus.statusHigh[3])
        else $error("sensor flag kept after both reads");
    gpio_rise_latch_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        $rose(bus.gpioLive[1]) && bus.ieGpio[2]
        |=> bus.gpioStatus[5] && bus.statusHigh[4])
        else $error("gpio rise not latched");
    gpio_read_clear_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        bus.rdGpioSts && bus.ieGpio == 8'h00
        |=> bus.gpioStatus[7:4] == 4'h0 && !bus.statusHigh[4])
        else $error("gpio latches not cleared");
    lock_event_kept_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        bus.rdStsFirst && bus.evt.lockChg && bus.ieLow[0]
        |=> bus.statusLow[0])
        else $error("lock event lost on clear");
    buffer_disabled_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        !bus.statusLow[4] && !bus.ieLow[4] |=> !bus.statusLow[4])
        else $error("disabled overflow flag set");
    camera_clear_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        bus.rdCamSts && !bus.evt.cameraRxErr |=> !bus.statusLow[3])
        else $error("camera flag not cleared");

endmodule

`default_nettype wire

// ===== design/rx_port_interrupt_status.sv
// Summary of operation
// - high bit 4 sets on any gpio condition, clears on gpio status read
// - high bit 3 flags sensor change, clears after both sensor reads
// - high bit 2 flags link encoding error, clears on second status read
// - high bit 1 flags control sequence error, clears on first status read
// - high bit 0 flags control crc error, clears on first status read
// - low bit 6 flags line length change, clears on second status read
// - low bit 5 flags line count change, clears on second status read
// - low bit 4 flags buffer overflow, clears on second status read
// - low bit 3 flags camera receiver error, cleared by reading 0x7a
// - low bit 2 flags link parity error, clears on first status read
// - low bit 1 flags port valid change, clears on first status read
// - low bit 0 flags lock change, clears on first status read
// - gpio status bits 7:4 latch gpio conditions, clear on read
// - gpio status bits 3:0 show live gpio values
// - port select at 0x4c routes accesses to one port's copy
// - events flag only when their enable bit is set, except sensor change, which always sets high bit 3
// - gpio condition met on enabled rising or falling edge
`include "rx_irq_defs.svh"
`default_nettype none

module rx_port_interrupt_status #(
    parameter int NUM_PORTS = 2
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // register access
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire rx_irq_pkg::reg_byte_t regWrData,
    output rx_irq_pkg::reg_byte_t regRdData,
    output logic regRdValid,
    // per-port events and gpio
    input wire rx_irq_pkg::port_evt_t [NUM_PORTS-1:0] portEvt,
    input wire rx_irq_pkg::gpio_t [NUM_PORTS-1:0] fwdGpio,
    // per-port pending flag
    output logic [NUM_PORTS-1:0] irqPending
);
    import rx_irq_pkg::*;

    localparam int SEL_W = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;

    typedef struct packed {
        logic [SEL_W-1:0] portSel;
        reg_byte_t [NUM_PORTS-1:0] ieHigh;
        reg_byte_t [NUM_PORTS-1:0] ieLow;
        reg_byte_t [NUM_PORTS-1:0] ieGpio;
        reg_byte_t rdData;
        logic rdValid;
        logic [NUM_PORTS-1:0] pending;
    } top_state_t;

    top_state_t s_r;
    top_state_t s_nxt;
    reg_byte_t [NUM_PORTS-1:0] highAll;
    reg_byte_t [NUM_PORTS-1:0] lowAll;
    reg_byte_t [NUM_PORTS-1:0] gpioAll;

    function automatic logic hit(logic [7:0] addr, logic [7:0] target);
        return addr == target;
    endfunction

    // ============================================================
    // per-port banks
    rx_irq_bank_if bankIf[NUM_PORTS] ();

    for (genvar g = 0; g < NUM_PORTS; g++) begin : gBank
        logic mine;
        logic rdMine;
        assign mine = s_r.portSel == SEL_W'(g);
        assign rdMine = regRdEn & mine;
        assign bankIf[g].evt = portEvt[g];
        assign bankIf[g].gpioLive = fwdGpio[g];
        assign bankIf[g].ieHigh = s_r.ieHigh[g];
        assign bankIf[g].ieLow = s_r.ieLow[g];
        assign bankIf[g].ieGpio = s_r.ieGpio[g];
        assign bankIf[g].rdStsFirst = rdMine
            & hit(regAddr, `RXI_ADDR_STS_FIRST);
        assign bankIf[g].rdStsSecond = rdMine
            & hit(regAddr, `RXI_ADDR_STS_SECOND);
        assign bankIf[g].rdCamSts = rdMine
            & hit(regAddr, `RXI_ADDR_CAM_STS);
        assign bankIf[g].rdSenRise = rdMine
            & hit(regAddr, `RXI_ADDR_SEN_RISE);
        assign bankIf[g].rdSenFall = rdMine
            & hit(regAddr, `RXI_ADDR_SEN_FALL);
        assign bankIf[g].rdGpioSts = rdMine
            & hit(regAddr, `RXI_ADDR_GPIO_STS);
        assign highAll[g] = bankIf[g].statusHigh;
        assign lowAll[g] = bankIf[g].statusLow;
        assign gpioAll[g] = bankIf[g].gpioStatus;

        rx_port_irq_bank uBank (
            .core_clk(core_clk),
            .rst_b(rst_b),
            .bus(bankIf[g])
        );
    end

    // ============================================================
    // register file and read mux
    always_comb begin
        s_nxt = s_r;
        s_nxt.rdValid = regRdEn;
        // pending trails the flags by one cycle to keep the output a flop
        for (int p = 0; p < NUM_PORTS; p++) begin
            s_nxt.pending[p] = (|highAll[p]) | (|lowAll[p]);
        end
        if (regWrEn) begin
            unique case (regAddr)
                `RXI_ADDR_PORT_SEL: begin
                    s_nxt.portSel = regWrData[SEL_W-1:0];
                end
                `RXI_ADDR_IE_HIGH: begin
                    s_nxt.ieHigh[s_r.portSel] = regWrData
                        & `RXI_IE_HIGH_MASK;
                end
                `RXI_ADDR_IE_LOW: begin
                    s_nxt.ieLow[s_r.portSel] = regWrData;
                end
                `RXI_ADDR_GPIO_IE: begin
                    s_nxt.ieGpio[s_r.portSel] = regWrData;
                end
                default: begin
                    s_nxt.portSel = s_r.portSel;
                end
            endcase
        end
        if (regRdEn) begin
            unique case (regAddr)
                `RXI_ADDR_PORT_SEL: begin
                    s_nxt.rdData = reg_byte_t'(s_r.portSel);
                end
                `RXI_ADDR_IE_HIGH: begin
                    s_nxt.rdData = s_r.ieHigh[s_r.portSel];
                end
                `RXI_ADDR_IE_LOW: begin
                    s_nxt.rdData = s_r.ieLow[s_r.portSel];
                end
                `RXI_ADDR_GPIO_IE: begin
                    s_nxt.rdData = s_r.ieGpio[s_r.portSel];
                end
                `RXI_ADDR_IRQ_HIGH: begin
                    s_nxt.rdData = highAll[s_r.portSel];
                end
                `RXI_ADDR_IRQ_LOW: begin
                    s_nxt.rdData = lowAll[s_r.portSel];
                end
                `RXI_ADDR_GPIO_STS: begin
                    s_nxt.rdData = gpioAll[s_r.portSel];
                end
                // source registers live elsewhere; they read as zero here
                default: begin
                    s_nxt.rdData = `RXI_RESET_BYTE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign regRdData = s_r.rdData;
    assign regRdValid = s_r.rdValid;
    assign irqPending = s_r.pending;

    // ============================================================
    // checks
    read_answer_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        regRdEn |=> regRdValid ##1 !regRdValid || $past(regRdEn))
        else $error("read answer not one cycle");
    port_select_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        regWrEn && hit(regAddr, `RXI_ADDR_PORT_SEL)
        |=> s_r.portSel == $past(regWrData[SEL_W-1:0]))
        else $error("port select not stored");
    live_gpio_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        regRdEn && hit(regAddr, `RXI_ADDR_GPIO_STS) && !regWrEn
        |=> regRdData[3:0] == $past(fwdGpio[s_r.portSel]))
        else $error("gpio live value wrong");
    // reserved status bits never read back as set
    high_reserved_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        regRdEn && hit(regAddr, `RXI_ADDR_IRQ_HIGH)
        |=> regRdData[7:5] == 3'h0)
        else $error("reserved high status bit set");
    low_reserved_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        regRdEn && hit(regAddr, `RXI_ADDR_IRQ_LOW) |=> !regRdData[7])
        else $error("reserved low status bit set");
    high_enable_mask_a: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        regRdEn && hit(regAddr, `RXI_ADDR_IE_HIGH)
        |=> regRdData[7:3] == 5'h00)
        else $error("unused high enable bits stored");

endmodule

`default_nettype wire

// ===== tb/reg_host.sv
`default_nettype none

module reg_host (
    // clock
    input wire logic core_clk,
    // register access
    output var logic [7:0] regAddr,
    output var logic regWrEn,
    output var logic regRdEn,
    output var rx_irq_pkg::reg_byte_t regWrData,
    input wire rx_irq_pkg::reg_byte_t regRdData,
    input wire logic regRdValid
);
    timeunit 1ns;
    timeprecision 100ps;
    import rx_irq_pkg::*;

    initial begin
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regWrData = 8'h00;
    end

    // ========================================================
    // byte accesses
    task automatic wr(input logic [7:0] a, input reg_byte_t d);
        @(posedge core_clk);
        #2;
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(posedge core_clk);
        #2;
        regWrEn = 1'b0;
        // idle lines never repeat the last value, so stale data is caught
        regAddr = ~a;
        regWrData = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output reg_byte_t d,
                      output logic ok);
        int n;
        @(posedge core_clk);
        #2;
        regAddr = a;
        regRdEn = 1'b1;
        @(posedge core_clk);
        #2;
        regRdEn = 1'b0;
        regAddr = ~a;
        n = 0;
        while (regRdValid !== 1'b1 && n < 4) begin
            @(posedge core_clk);
            #2;
            n++;
        end
        ok = (regRdValid === 1'b1);
        d = regRdData;
    endtask

    task automatic selPort(input int p);
        wr(8'h4c, 8'(p));
    endtask

endmodule

`default_nettype wire

// ===== tb/tb.sv
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import rx_irq_pkg::*;

    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] regAddr;
    logic regWrEn;
    logic regRdEn;
    reg_byte_t regWrData;
    reg_byte_t regRdData;
    logic regRdValid;
    port_evt_t [1:0] evt = '0;
    gpio_t [1:0] gpio = '0;
    logic [1:0] irqPending;
    int error_cnt = 0;
    int n_checks = 0;
    logic [15:0] expTab [11] = '{16'h0800, 16'h0001, 16'h0002, 16'h0004,
        16'h0008, 16'h0010, 16'h0020, 16'h0040, 16'h0100, 16'h0200,
        16'h0400};
    logic [7:0] clrTab [11] = '{8'hdf, 8'h60, 8'h60, 8'h60, 8'h7a, 8'h61,
        8'h61, 8'h61, 8'h60, 8'h60, 8'h61};
    logic [7:0] clrList [5] = '{8'h60, 8'h61, 8'h7a, 8'hde, 8'hdf};
    logic [7:0] rstList [7] = '{8'hda, 8'hdb, 8'hdc, 8'hd8, 8'hd9, 8'hdd,
        8'h4c};

    always #12.5 core_clk = ~core_clk;

    rx_port_interrupt_status #(.NUM_PORTS(2)) rx_port_interrupt_status_i (
        .core_clk(core_clk), .rst_b(rst_b), .regAddr(regAddr),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData),
        .regRdData(regRdData), .regRdValid(regRdValid), .portEvt(evt),
        .fwdGpio(gpio), .irqPending(irqPending)
    );

    reg_host reg_host_i (
        .core_clk(core_clk), .regAddr(regAddr), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid)
    );

    // ========================================================
    // checking and access helpers
    task automatic wrap_up();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input reg_byte_t got, input reg_byte_t exp);
        n_checks++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    endtask

    task automatic rc(input logic [7:0] a, input reg_byte_t exp);
        reg_byte_t d;
        logic ok;
        reg_host_i.rd(a, d, ok);
        // a missing answer counts once and ends the run
        chk({7'h00, ok}, 8'h01);
        if (ok !== 1'b1) begin
            wrap_up();
        end else begin
            chk(d, exp);
        end
    endtask

    task automatic st(input reg_byte_t hi, input reg_byte_t lo);
        rc(8'hda, hi);
        rc(8'hdb, lo);
    endtask

    task automatic pulse(input int p, input port_evt_t e);
        @(posedge core_clk);
        #2;
        evt[p] = e;
        @(posedge core_clk);
        #2;
        evt[p] = '0;
    endtask

    // ========================================================
    // main sequence
    initial begin
        logic [15:0] exp;
        logic [7:0] clr;
        logic [7:0] part;
        gpio_t b;
        repeat (6) @(posedge core_clk);
        #2;
        rst_b = 1'b1;
        foreach (rstList[k]) begin
            rc(rstList[k], 8'h00);
        end
        reg_host_i.wr(8'hd8, 8'hff);
        rc(8'hd8, 8'h07);
        reg_host_i.wr(8'hd9, 8'hff);
        rc(8'hd9, 8'hff);
        reg_host_i.wr(8'hda, 8'hff);
        reg_host_i.wr(8'h33, 8'hff);
        rc(8'hda, 8'h00);
        rc(8'h33, 8'h00);
        for (int i = 0; i < 11; i++) begin
            exp = expTab[i];
            clr = clrTab[i];
            part = (i == 0) ? 8'hde : ((clr == 8'h60) ? 8'h61 : 8'h60);
            pulse(0, port_evt_t'(11'h001 << i));
            st(exp[15:8], exp[7:0]);
            chk({6'h00, irqPending}, 8'h01);
            rc(part, 8'h00);
            st(exp[15:8], exp[7:0]);
            rc(clr, 8'h00);
            st(8'h00, 8'h00);
        end
        chk({6'h00, irqPending}, 8'h00);
        // second port starts with all enables off
        reg_host_i.selPort(1);
        pulse(1, '1);
        st(8'h08, 8'h00);
        reg_host_i.wr(8'hd8, 8'h07);
        reg_host_i.wr(8'hd9, 8'hff);
        pulse(1, '1);
        st(8'h0f, 8'h7f);
        chk({6'h00, irqPending}, 8'h02);
        reg_host_i.selPort(0);
        st(8'h00, 8'h00);
        reg_host_i.selPort(1);
        foreach (clrList[k]) begin
            rc(clrList[k], 8'h00);
        end
        st(8'h00, 8'h00);
        reg_host_i.selPort(0);
        for (int i = 0; i < 4; i++) begin
            b = 4'(1 << i);
            reg_host_i.wr(8'hdd, 8'h01 << (2 * i));
            gpio[0] = b;
            rc(8'hda, 8'h10);
            rc(8'hdc, {b, b});
            rc(8'hda, 8'h00);
            reg_host_i.wr(8'hdd, 8'h02 << (2 * i));
            gpio[0] = 4'h0;
            rc(8'hdc, {b, 4'h0});
            gpio[0] = b;
            rc(8'hdc, {4'h0, b});
            gpio[0] = 4'h0;
            rc(8'hdc, {b, 4'h0});
        end
        pulse(0, port_evt_t'(11'h002));
        fork
            rc(8'h60, 8'h00);
            pulse(0, port_evt_t'(11'h002));
        join
        st(8'h00, 8'h01);
        rc(8'h60, 8'h00);
        st(8'h00, 8'h00);
        // reset again in mid-run: enables must fall back to zero
        @(posedge core_clk);
        #2;
        rst_b = 1'b0;
        @(posedge core_clk);
        #2;
        rst_b = 1'b1;
        rc(8'hd9, 8'h00);
        rc(8'hd8, 8'h00);
        wrap_up();
    end

endmodule

`default_nettype wire
